/* File: hw/gp_port_defs.svh */
`ifndef GP_PORT_DEFS_SVH
`define GP_PORT_DEFS_SVH

`define GP_CTRL_ADDR        16'h003c
`define GP_TIMER_SEL_BIT    15
`define GP_DIR_HI           11
`define GP_DIR_LO           8
`define GP_VAL_HI           3
`define GP_VAL_LO           0
`define GP_TIMER_SEL_RESET  1'b0
`define GP_DIR_RESET        4'h0
`define GP_VAL_RESET        4'h0
`define GP_BRANCH_PIN       2
`define GP_TIMER_PIN        3

`endif

/* File: hw/gp_port_pkg.sv */
package gp_port_pkg;
    // one subsystem's data-memory access to its own port register
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pin_drive_s;
endpackage : gp_port_pkg

/* File: hw/gp_pin_port_with_timer_mux.sv */
// Contract
// - own control register per subsystem at 0x3c
// - four independent pins per subsystem
// - bit 15 routes timer to pin 3
// - bits 11:8 set pin directions
// - bits 3:0 drive or sense pins
// - bits 14:12 and 7:4 reserved
// - input pin 2 feeds branch condition
// - timer on pin 3 only in host-port mode
// - interface select low host-port, high memory
`timescale 1ns/1ns
`include "gp_port_defs.svh"
module gp_pin_port_with_timer_mux
    import gp_port_pkg::*;
#(
    parameter int SUBSYS_COUNT = 2,
    parameter int PIN_COUNT    = 4
) (
    input  wire logic                               ref_clk_in,
    input  wire logic                               rst_n_in,
    input  wire mem_req_s   [SUBSYS_COUNT-1:0]      mem_req_in,
    output logic            [SUBSYS_COUNT-1:0][15:0] mem_rdata_out,
    output logic            [SUBSYS_COUNT-1:0]      mem_rvalid_out,
    input  wire logic       [SUBSYS_COUNT-1:0]      timer_out_in,
    input  wire logic                               ext_interface_select_in,
    input  wire logic       [SUBSYS_COUNT-1:0][3:0] port_pin_in,
    output logic            [SUBSYS_COUNT-1:0][3:0] port_pin_out,
    output logic            [SUBSYS_COUNT-1:0][3:0] port_pin_oe_out,
    output logic            [SUBSYS_COUNT-1:0]      branch_condition_input_out
);

    // the register layout fixes four pins per subsystem; PIN_COUNT only
    // sizes the per-pin loop and must stay at four
    genvar s;
    genvar p;

    generate
        for (s = 0; s < SUBSYS_COUNT; s++) begin : g_subsys

            // control fields of this subsystem's own register
            logic        timer_out_select_reg;
            logic [3:0]  pin_direction_reg;
            logic [3:0]  pin_value_reg;

            // registered outputs toward the cpu
            logic        branch_level_reg;
            logic [15:0] read_data_reg;
            logic        read_valid_reg;

            // decode and routing
            logic        hit;
            logic        write_hit;
            logic        read_hit;
            logic        host_mode;
            logic        timer_on_pin3;
            logic        branch_pin_is_input;
            logic [15:0] read_word;

            // per-pin results, one driver per bit from the pin loop
            wire  [3:0]  pin_read;
            wire  [3:0]  drive_out;
            wire  [3:0]  drive_oe;
            pin_drive_s  drive;

            //----------------------------------------------------------
            // address decode
            //----------------------------------------------------------

            // each subsystem decodes only its own request lane
            assign hit       = (mem_req_in[s].addr == `GP_CTRL_ADDR);
            assign write_hit = mem_req_in[s].wr & hit;
            assign read_hit  = mem_req_in[s].rd & hit;

            //----------------------------------------------------------
            // external interface mode
            //----------------------------------------------------------

            // memory mode blocks the timer even with the select bit set
            assign host_mode     = ~ext_interface_select_in;
            assign timer_on_pin3 = timer_out_select_reg & host_mode;

            //----------------------------------------------------------
            // control register fields, one process per field
            //----------------------------------------------------------

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    timer_out_select_reg <= `GP_TIMER_SEL_RESET;
                end else if (write_hit) begin
                    timer_out_select_reg <= mem_req_in[s].wdata[`GP_TIMER_SEL_BIT];
                end
            end

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    pin_direction_reg <= `GP_DIR_RESET;
                end else if (write_hit) begin
                    pin_direction_reg <= mem_req_in[s].wdata[`GP_DIR_HI:`GP_DIR_LO];
                end
            end

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    pin_value_reg <= `GP_VAL_RESET;
                end else if (write_hit) begin
                    pin_value_reg <= mem_req_in[s].wdata[`GP_VAL_HI:`GP_VAL_LO];
                end
            end

            //----------------------------------------------------------
            // per-pin drive and readback
            //----------------------------------------------------------

            for (p = 0; p < PIN_COUNT; p++) begin : g_pin
                if (p == `GP_TIMER_PIN) begin : g_timer_pin
                    // the timer overrides the direction bit; in memory mode
                    // the pin is released rather than driven low
                    assign drive_out[p] = timer_out_select_reg
                        ? (timer_on_pin3 & timer_out_in[s])
                        : pin_value_reg[p];
                    assign drive_oe[p]  = timer_out_select_reg
                        ? timer_on_pin3
                        : pin_direction_reg[p];
                    // readback shows the timer whenever it is selected,
                    // so software can poll it in either mode
                    assign pin_read[p]  = timer_out_select_reg
                        ? timer_out_in[s]
                        : (pin_direction_reg[p] ? pin_value_reg[p]
                                                : port_pin_in[s][p]);
                end else begin : g_plain_pin
                    assign drive_out[p] = pin_value_reg[p];
                    assign drive_oe[p]  = pin_direction_reg[p];
                    // an output pin reads back its stored level, not the
                    // pad, so a loaded pin cannot corrupt the readback
                    assign pin_read[p]  = pin_direction_reg[p]
                        ? pin_value_reg[p]
                        : port_pin_in[s][p];
                end
            end

            assign drive.out = drive_out;
            assign drive.oe  = drive_oe;

            // handshake-free pin outputs stay combinational so the timer
            // edge reaches the pad without a cycle of delay
            always_comb begin
                port_pin_out[s]    = drive.out;
                port_pin_oe_out[s] = drive.oe;
            end

            //----------------------------------------------------------
            // branch condition
            //----------------------------------------------------------

            assign branch_pin_is_input = ~pin_direction_reg[`GP_BRANCH_PIN];

            // held high (inactive) while pin 2 is an output
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    branch_level_reg <= 1'b1;
                end else if (branch_pin_is_input) begin
                    branch_level_reg <= port_pin_in[s][`GP_BRANCH_PIN];
                end else begin
                    branch_level_reg <= 1'b1;
                end
            end

            always_comb begin
                branch_condition_input_out[s] = branch_level_reg;
            end

            //----------------------------------------------------------
            // readback
            //----------------------------------------------------------

            // reserved bits read as zero and are never stored
            assign read_word = {timer_out_select_reg, 3'h0, pin_direction_reg,
                                4'h0, pin_read};

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    read_valid_reg <= 1'b0;
                end else begin
                    // every read is answered, mapped or not
                    read_valid_reg <= mem_req_in[s].rd;
                end
            end

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    read_data_reg <= 16'h0000;
                end else if (read_hit) begin
                    read_data_reg <= read_word;
                end else begin
                    read_data_reg <= 16'h0000;
                end
            end

            always_comb begin
                mem_rdata_out[s]  = read_data_reg;
                mem_rvalid_out[s] = read_valid_reg;
            end

        end
    endgenerate


endmodule : gp_pin_port_with_timer_mux

/* File: sim/gp_port_checker.sv */
`timescale 1ns/1ns
module gp_port_checker import gp_port_pkg::*; #(parameter int SUBSYS_COUNT = 2, PIN_COUNT = 4) (
    input wire logic                          ref_clk_in, rst_n_in, ext_interface_select_in,
    input wire mem_req_s [SUBSYS_COUNT-1:0]   mem_req_in,
    input wire logic [SUBSYS_COUNT-1:0][15:0] mem_rdata_out,
    input wire logic [SUBSYS_COUNT-1:0]       mem_rvalid_out, timer_out_in, branch_condition_input_out,
    input wire logic [SUBSYS_COUNT-1:0][3:0]  port_pin_in, port_pin_out, port_pin_oe_out);
    wire mem_req_s   w = mem_req_in[0];
    wire logic       h = w.wr && w.addr == 16'h003c;
    wire logic [3:0] oe = port_pin_oe_out[0];
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wr_dir_a: assert property (h |=> oe[2:0] == $past(w.wdata[10:8]))
        else $error("direction not taken from write");
    wr_val_a: assert property (h |=> (port_pin_out[0][2:0] & oe[2:0]) ==
        $past(w.wdata[2:0] & w.wdata[10:8])) else $error("driven level wrong");
    miss_zero_a: assert property (w.rd && w.addr != 16'h003c |=>
        mem_rvalid_out[0] && mem_rdata_out[0] == 16'h0000) else $error("unmapped read bad");
    rsv_zero_a: assert property (mem_rvalid_out[0] |-> mem_rdata_out[0][14:12] == 3'h0 &&
        mem_rdata_out[0][7:4] == 4'h0) else $error("reserved bits not zero");
    tmr_host_a: assert property (h && w.wdata[15] ##1 !ext_interface_select_in |->
        oe[3] && port_pin_out[0][3] == timer_out_in[0]) else $error("timer not on pin 3");
    tmr_mem_a: assert property (h && w.wdata[15] ##1 ext_interface_select_in |-> !oe[3])
        else $error("timer driven in memory mode");
    branch_a: assert property ($past(rst_n_in) && !oe[2] && $past(!oe[2]) |->
        branch_condition_input_out[0] == $past(port_pin_in[0][2])) else $error("branch input bad");
    indep_a: assert property (h && !mem_req_in[1].wr |=> $stable(port_pin_oe_out[1]))
        else $error("other subsystem disturbed");
    cover property (h && w.wdata[15]);
    cover property (h && ext_interface_select_in);
    cover property (w.rd && w.addr != 16'h003c);
endmodule : gp_port_checker
bind gp_pin_port_with_timer_mux gp_port_checker #(.SUBSYS_COUNT(SUBSYS_COUNT),
    .PIN_COUNT(PIN_COUNT)) i_gp_port_checker (.*);

/* File: sim/board_pins_model.sv */
`timescale 1ns/1ns
module board_pins_model (
    input  wire logic [1:0][3:0] drv_in, oe_in, lvl_in,
    output logic      [1:0][3:0] pin_out);
    // a driven pin reads back its own level, an undriven one the board level
    assign pin_out = (oe_in & drv_in) | (~oe_in & lvl_in);
endmodule : board_pins_model

/* File: sim/gp_pin_port_with_timer_mux_bench.sv */
`timescale 1ns/1ns
module gp_pin_port_with_timer_mux_bench;
    import gp_port_pkg::*;
    logic             ref_clk_in = 0, rst_n_in = 0, ext = 0;
    logic [1:0]       tm = '0, rv, br;
    mem_req_s [1:0]   req = '0;
    logic [1:0][15:0] rd;
    logic [1:0][3:0]  lvl = '0, pin_in, po, oe;
    int               errors = 0, total_checks = 0;
    // wdata, board level, {ext, timer}, read data, output enables
    logic [43:0] rows [5] = '{44'h0f0a_5_0_0f0a_f, 44'h00f5_9_0_0009_0,
        44'h8000_6_1_800e_8, 44'h8000_0_3_8008_0, 44'h0c03_5_0_0c01_c};
    always #5 ref_clk_in = ~ref_clk_in;
    gp_pin_port_with_timer_mux i_gp_pin_port_with_timer_mux (.ref_clk_in, .rst_n_in,
        .mem_req_in(req), .mem_rdata_out(rd), .mem_rvalid_out(rv), .timer_out_in(tm),
        .ext_interface_select_in(ext), .port_pin_in(pin_in), .port_pin_out(po),
        .port_pin_oe_out(oe), .branch_condition_input_out(br));
    board_pins_model i_board_pins_model (.drv_in(po), .oe_in(oe), .lvl_in(lvl), .pin_out(pin_in));
    task automatic acc(input int s, input logic w, input logic [15:0] a, d);
        @(posedge ref_clk_in);
        req[s] <= '{w, !w, a, d};
        @(posedge ref_clk_in);
        req[s] <= '0;
        @(negedge ref_clk_in);
    endtask : acc
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        acc(0, 0, 16'h003c, 16'h0000);
        chk(rd[0], 16'h0000);
        chk({15'h0, br[0]}, 16'h0000);
        acc(1, 1, 16'h003c, 16'h0f05);
        foreach (rows[i]) begin
            @(posedge ref_clk_in);
            {lvl[0], ext, tm[0]} <= {rows[i][27:24], rows[i][21:20]};
            acc(0, 1, 16'h003c, rows[i][43:28]);
            acc(0, 0, 16'h003c, 16'h0000);
            chk(rd[0], rows[i][19:4]);
            chk({12'h0, oe[0]}, {12'h0, rows[i][3:0]});
            chk({15'h0, br[0]}, {15'h0, rows[i][38] | lvl[0][2]});
            $display("row %0d done", i);
        end
        chk({12'h0, oe[1]}, 16'h000f);
        acc(0, 1, 16'h003d, 16'hffff);
        acc(0, 0, 16'h003d, 16'h0000);
        chk(rd[0], 16'h0000);
        chk({15'h0, rv[0]}, 16'h0001);
        acc(0, 0, 16'h003c, 16'h0000);
        chk(rd[0], 16'h0c01);
        acc(1, 0, 16'h003c, 16'h0000);
        chk(rd[1], 16'h0f05);
        $display("map test done");
        final_report();
    end
endmodule : gp_pin_port_with_timer_mux_bench
